/* File: src/timer16_pkg.sv */
//Behaviour
//- With the filter on, the capture level changes after four equal pin samples.
//- The filter delays every capture event by four more clock cycles.
//- Edge select low captures on falling edges, high on rising edges.
//- A capture edge copies the counter to capture_value and sets capture_flag.
//- Modes using capture_value as top disconnect the pin; no captures happen.
//- Clock codes 0 to 5: stopped, then divide by 1, 8, 64, 256, 1024.
//- Code 6 counts falling external pin edges, code 7 counts rising edges.
//- External pin edges count even when the pin serves as an output.
//- Force compare strobes act only in non-PWM modes, otherwise ignored.
//- A force strobe applies a match to its output per the current mode.
//- A forced match sets no flag and never clears the counter.
//- The force compare bits always read as zero.
//- Every 16-bit register has low byte at base, high at base plus one.
//- A counter write suppresses compare matches on the next timer tick.
//- Both 16-bit compare values are compared with the counter on every timer tick.
//- A compare flag sets in the tick after counter equals the compare value.
//- The capture flag clears on its vector acknowledge or by writing one.
package timer16_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_CAPTURE_L = 6'h22;
  localparam logic [5:0] IDX_CAPTURE_H = 6'h23;
  localparam logic [5:0] IDX_COMPARE_B_L = 6'h24;
  localparam logic [5:0] IDX_COMPARE_B_H = 6'h25;
  localparam logic [5:0] IDX_COMPARE_A_L = 6'h26;
  localparam logic [5:0] IDX_COMPARE_A_H = 6'h27;
  localparam logic [5:0] IDX_COUNTER_L = 6'h28;
  localparam logic [5:0] IDX_COUNTER_H = 6'h29;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h2a;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h2b;
  localparam logic [5:0] IDX_FORCE = 6'h2c;
  localparam logic [5:0] IDX_CAPTURE_CLOCK = 6'h2d;
  localparam logic [5:0] IDX_WAVEFORM_CTRL = 6'h2e;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and writable masks.
  localparam int FLAG_CAPTURE = 5;
  localparam int FLAG_COMPARE_B = 2;
  localparam int FLAG_COMPARE_A = 1;
  localparam int FLAG_OVERFLOW = 0;
  localparam logic [7:0] FLAG_MASK = 8'h27;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int FILTER_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam logic [7:0] CLOCK_CTRL_MASK = 8'hdf;
  localparam logic [7:0] WAVE_CTRL_MASK = 8'hf3;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, prescaler taps and counter tops.
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int FILTER_SAMPLES = 4;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03f;
  localparam logic [9:0] DIV256_LAST = 10'h0ff;
  localparam logic [9:0] DIV1024_LAST = 10'h3ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // Clock source codes.
  typedef enum logic [2:0] {
    CLK_STOP, CLK_DIV1, CLK_DIV8, CLK_DIV64, CLK_DIV256, CLK_DIV1024,
    CLK_EXT_FALL, CLK_EXT_RISE
  } clock_source_t;

  // Whole state of the timer, registered in one place.
  typedef struct packed {
    logic [15:0] counter_value;
    logic [15:0] capture_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [7:0] temp_high;
    logic [7:0] capture_clock_control;
    logic [7:0] waveform_control;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [9:0] prescale;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] cap_sync;
    logic [3:0] cap_hist;
    logic cap_level;
    logic cap_prev;
    logic match_block;
    logic waveform_output_a;
    logic waveform_output_b;
    logic [31:0] prdata;
  } timer_state_t;

endpackage : timer16_pkg

/* File: src/timer16_capture_compare_regs.sv */
`timescale 1ns/1ps
module timer16_capture_compare_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  input wire logic external_count_pin,
  input wire logic [7:0] vector_ack,
  output logic waveform_output_a,
  output logic waveform_output_a_en,
  output logic waveform_output_b,
  output logic waveform_output_b_en,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Mode decoding helpers.

  // Normal mode and the two clear-on-match modes are the non-PWM modes.
  function automatic logic is_non_pwm(input logic [3:0] mode);
    is_non_pwm = (mode == 4'h0) || (mode == 4'h4) || (mode == 4'hc);
  endfunction : is_non_pwm

  // Modes that take capture_value as the counter top.
  function automatic logic capture_is_top(input logic [3:0] mode);
    capture_is_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) ||
                     (mode == 4'he);
  endfunction : capture_is_top

  // Top value of the counting sequence for the selected mode.
  function automatic logic [15:0] top_of(input logic [3:0] mode,
                                         input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    if (capture_is_top(mode)) begin
      top_of = cap;
    end else if ((mode == 4'h4) || (mode == 4'h9) || (mode == 4'hb) ||
                 (mode == 4'hf)) begin
      top_of = cmp_a;
    end else if ((mode == 4'h1) || (mode == 4'h5)) begin
      top_of = timer16_pkg::TOP_8BIT;
    end else if ((mode == 4'h2) || (mode == 4'h6)) begin
      top_of = timer16_pkg::TOP_9BIT;
    end else if ((mode == 4'h3) || (mode == 4'h7)) begin
      top_of = timer16_pkg::TOP_10BIT;
    end else begin
      top_of = timer16_pkg::TOP_MAX;
    end
  endfunction : top_of

  // Output action on a match or at the bottom of the count.
  function automatic logic wave_action(input logic [1:0] com,
                                       input logic cur,
                                       input logic non_pwm,
                                       input logic match,
                                       input logic bottom);
    wave_action = cur;
    if (non_pwm) begin
      if (match) begin
        case (com)
          2'b01: wave_action = ~cur;
          2'b10: wave_action = 1'b0;
          2'b11: wave_action = 1'b1;
          default: wave_action = cur;
        endcase
      end
    end else if (com[1]) begin
      // Bottom restores the idle level; a match then drives the other one.
      if (bottom) begin
        wave_action = ~com[0];
      end
      if (match) begin
        wave_action = com[0];
      end
    end
  endfunction : wave_action

  //////////////////////////////////////////////////////////////////////////////
  // State and decoded controls.

  timer16_pkg::timer_state_t state_r;
  timer16_pkg::timer_state_t state_nxt;

  logic [3:0] waveform_mode;
  logic [1:0] compare_output_mode_a;
  logic [1:0] compare_output_mode_b;
  timer16_pkg::clock_source_t clock_source_select;
  logic capture_noise_filter_enable;
  logic capture_edge_select;
  logic [5:0] reg_index;
  logic mapped;

  assign waveform_mode = {state_r.capture_clock_control[4:3],
                          state_r.waveform_control[1:0]};
  assign compare_output_mode_a = state_r.waveform_control[7:6];
  assign compare_output_mode_b = state_r.waveform_control[5:4];
  assign clock_source_select =
    timer16_pkg::clock_source_t'(state_r.capture_clock_control[2:0]);
  assign capture_noise_filter_enable =
    state_r.capture_clock_control[timer16_pkg::FILTER_BIT];
  assign capture_edge_select =
    state_r.capture_clock_control[timer16_pkg::EDGE_BIT];
  assign reg_index = paddr[7:2];

  // Address decode shared by the bus answer and the register update.
  always_comb begin
    mapped = 1'b0;
    if ((reg_index >= timer16_pkg::IDX_CAPTURE_L) &&
        (reg_index <= timer16_pkg::IDX_COUNTER_H)) begin
      mapped = 1'b1;
    end else if ((reg_index >= timer16_pkg::IDX_IRQ_STATUS) &&
                 (reg_index <= timer16_pkg::IDX_WAVEFORM_CTRL)) begin
      mapped = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Timer behaviour first, then the bus, so a bus write to the counter wins
  // over the increment of the same cycle.
  always_comb begin
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic cap_src;
    logic cap_edge;
    logic match_a;
    logic match_b;
    logic at_top;
    logic non_pwm;
    logic [15:0] top;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic bus_setup;
    logic bus_write;
    tick = 1'b0;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    cap_src = 1'b0;
    cap_edge = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    at_top = 1'b0;
    non_pwm = is_non_pwm(waveform_mode);
    top = top_of(waveform_mode, state_r.compare_value_a,
                 state_r.capture_value);
    flag_set = timer16_pkg::RESET_BYTE;
    flag_clr = vector_ack & timer16_pkg::FLAG_MASK;
    bus_setup = psel && !penable;
    bus_write = psel && penable && pwrite && mapped;
    state_nxt = state_r;
    state_nxt.prescale = state_r.prescale + 10'h001;

    // Pins pass two flops; only the second flop feeds the logic. The pin's
    // direction is not seen here, so output-driven levels count too.
    state_nxt.ext_sync = {state_r.ext_sync[0], external_count_pin};
    state_nxt.ext_prev = state_r.ext_sync[1];
    ext_rise = state_r.ext_sync[1] && !state_r.ext_prev;
    ext_fall = !state_r.ext_sync[1] && state_r.ext_prev;
    state_nxt.cap_sync = {state_r.cap_sync[0], capture_input_pin};

    // Noise filter: the level follows only after four equal samples, which
    // costs exactly four extra cycles of capture latency.
    // The newest sample counts as one of the four, so the filtered level
    // moves in the same cycle as the fourth equal sample arrives.
    state_nxt.cap_hist = {state_r.cap_hist[2:0], state_r.cap_sync[1]};
    if (&state_nxt.cap_hist) begin
      state_nxt.cap_level = 1'b1;
    end else if (~|state_nxt.cap_hist) begin
      state_nxt.cap_level = 1'b0;
    end
    if (capture_noise_filter_enable) begin
      cap_src = state_r.cap_level;
    end else begin
      cap_src = state_r.cap_sync[1];
    end
    state_nxt.cap_prev = cap_src;
    if (capture_edge_select) begin
      cap_edge = cap_src && !state_r.cap_prev;
    end else begin
      cap_edge = !cap_src && state_r.cap_prev;
    end

    // Capture is cut off while capture_value serves as the top.
    if (cap_edge && !capture_is_top(waveform_mode)) begin
      state_nxt.capture_value = state_r.counter_value;
      flag_set[timer16_pkg::FLAG_CAPTURE] = 1'b1;
    end

    // Timer clock enable from the prescaler or the external pin.
    case (clock_source_select)
      timer16_pkg::CLK_STOP: tick = 1'b0;
      timer16_pkg::CLK_DIV1: tick = 1'b1;
      timer16_pkg::CLK_DIV8:
        tick = (state_r.prescale & timer16_pkg::DIV8_LAST) ==
               timer16_pkg::DIV8_LAST;
      timer16_pkg::CLK_DIV64:
        tick = (state_r.prescale & timer16_pkg::DIV64_LAST) ==
               timer16_pkg::DIV64_LAST;
      timer16_pkg::CLK_DIV256:
        tick = (state_r.prescale & timer16_pkg::DIV256_LAST) ==
               timer16_pkg::DIV256_LAST;
      timer16_pkg::CLK_DIV1024:
        tick = state_r.prescale == timer16_pkg::DIV1024_LAST;
      timer16_pkg::CLK_EXT_FALL: tick = ext_fall;
      default: tick = ext_rise;
    endcase

    // Counting, compare and top. Flags land with the edge that leaves the
    // matching count, so they show in the following timer clock cycle.
    if (tick) begin
      match_a = (state_r.counter_value == state_r.compare_value_a) &&
                !state_r.match_block;
      match_b = (state_r.counter_value == state_r.compare_value_b) &&
                !state_r.match_block;
      at_top = state_r.counter_value == top;
      state_nxt.match_block = 1'b0;
      flag_set[timer16_pkg::FLAG_COMPARE_A] = match_a;
      flag_set[timer16_pkg::FLAG_COMPARE_B] = match_b;
      if (at_top) begin
        state_nxt.counter_value = timer16_pkg::RESET_WORD;
        flag_set[timer16_pkg::FLAG_OVERFLOW] = 1'b1;
        if (capture_is_top(waveform_mode)) begin
          flag_set[timer16_pkg::FLAG_CAPTURE] = 1'b1;
        end
      end else begin
        state_nxt.counter_value = state_r.counter_value + 16'h0001;
      end
      state_nxt.waveform_output_a =
        wave_action(compare_output_mode_a, state_r.waveform_output_a,
                    non_pwm, match_a, at_top);
      state_nxt.waveform_output_b =
        wave_action(compare_output_mode_b, state_r.waveform_output_b,
                    non_pwm, match_b, at_top);
    end

    // Setup phase: load read data and, for a low byte, latch the high byte.
    if (bus_setup && !pwrite) begin
      state_nxt.prdata = 32'h0000_0000;
      if (reg_index == timer16_pkg::IDX_CAPTURE_L) begin
        state_nxt.prdata[7:0] = state_r.capture_value[7:0];
        state_nxt.temp_high = state_r.capture_value[15:8];
      end else if (reg_index == timer16_pkg::IDX_COMPARE_B_L) begin
        state_nxt.prdata[7:0] = state_r.compare_value_b[7:0];
        state_nxt.temp_high = state_r.compare_value_b[15:8];
      end else if (reg_index == timer16_pkg::IDX_COMPARE_A_L) begin
        state_nxt.prdata[7:0] = state_r.compare_value_a[7:0];
        state_nxt.temp_high = state_r.compare_value_a[15:8];
      end else if (reg_index == timer16_pkg::IDX_COUNTER_L) begin
        state_nxt.prdata[7:0] = state_r.counter_value[7:0];
        state_nxt.temp_high = state_r.counter_value[15:8];
      end else if ((reg_index == timer16_pkg::IDX_CAPTURE_H) ||
                   (reg_index == timer16_pkg::IDX_COMPARE_B_H) ||
                   (reg_index == timer16_pkg::IDX_COMPARE_A_H) ||
                   (reg_index == timer16_pkg::IDX_COUNTER_H)) begin
        state_nxt.prdata[7:0] = state_r.temp_high;
      end else if (reg_index == timer16_pkg::IDX_IRQ_STATUS) begin
        state_nxt.prdata[7:0] = state_r.irq_status;
      end else if (reg_index == timer16_pkg::IDX_IRQ_MASK) begin
        state_nxt.prdata[7:0] = state_r.irq_mask;
      end else if (reg_index == timer16_pkg::IDX_FORCE) begin
        state_nxt.prdata[7:0] = timer16_pkg::RESET_BYTE;
      end else if (reg_index == timer16_pkg::IDX_CAPTURE_CLOCK) begin
        state_nxt.prdata[7:0] = state_r.capture_clock_control;
      end else if (reg_index == timer16_pkg::IDX_WAVEFORM_CTRL) begin
        state_nxt.prdata[7:0] = state_r.waveform_control;
      end
    end

    // Access phase write. High bytes go to the shared latch; a low byte
    // commits both halves at once.
    if (bus_write) begin
      if ((reg_index == timer16_pkg::IDX_CAPTURE_H) ||
          (reg_index == timer16_pkg::IDX_COMPARE_B_H) ||
          (reg_index == timer16_pkg::IDX_COMPARE_A_H) ||
          (reg_index == timer16_pkg::IDX_COUNTER_H)) begin
        state_nxt.temp_high = pwdata[7:0];
      end else if (reg_index == timer16_pkg::IDX_CAPTURE_L) begin
        state_nxt.capture_value = {state_r.temp_high, pwdata[7:0]};
      end else if (reg_index == timer16_pkg::IDX_COMPARE_B_L) begin
        state_nxt.compare_value_b = {state_r.temp_high, pwdata[7:0]};
      end else if (reg_index == timer16_pkg::IDX_COMPARE_A_L) begin
        state_nxt.compare_value_a = {state_r.temp_high, pwdata[7:0]};
      end else if (reg_index == timer16_pkg::IDX_COUNTER_L) begin
        state_nxt.counter_value = {state_r.temp_high, pwdata[7:0]};
        state_nxt.match_block = 1'b1;
      end else if (reg_index == timer16_pkg::IDX_IRQ_STATUS) begin
        flag_clr = flag_clr | (pwdata[7:0] & timer16_pkg::FLAG_MASK);
      end else if (reg_index == timer16_pkg::IDX_IRQ_MASK) begin
        state_nxt.irq_mask = pwdata[7:0] & timer16_pkg::FLAG_MASK;
      end else if (reg_index == timer16_pkg::IDX_FORCE) begin
        // Forced matches touch only the outputs: no flag, no counter clear.
        if (non_pwm && pwdata[timer16_pkg::FORCE_A_BIT]) begin
          state_nxt.waveform_output_a =
            wave_action(compare_output_mode_a, state_r.waveform_output_a,
                        1'b1, 1'b1, 1'b0);
        end
        if (non_pwm && pwdata[timer16_pkg::FORCE_B_BIT]) begin
          state_nxt.waveform_output_b =
            wave_action(compare_output_mode_b, state_r.waveform_output_b,
                        1'b1, 1'b1, 1'b0);
        end
      end else if (reg_index == timer16_pkg::IDX_CAPTURE_CLOCK) begin
        state_nxt.capture_clock_control =
          pwdata[7:0] & timer16_pkg::CLOCK_CTRL_MASK;
      end else if (reg_index == timer16_pkg::IDX_WAVEFORM_CTRL) begin
        state_nxt.waveform_control = pwdata[7:0] & timer16_pkg::WAVE_CTRL_MASK;
      end
    end

    // A flag event in the clearing cycle survives: set wins over clear.
    state_nxt.irq_status = (state_r.irq_status & ~flag_clr) | flag_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // Every field resets to a constant; pins are only sampled after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Zero wait states keep the bus simple; read data was loaded at setup.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state_r.prdata;
  assign irq = |(state_r.irq_status & state_r.irq_mask);

  // The output driver is enabled (low) whenever its channel mode is not
  // disconnected.
  assign waveform_output_a = state_r.waveform_output_a;
  assign waveform_output_b = state_r.waveform_output_b;
  assign waveform_output_a_en = ~|compare_output_mode_a;
  assign waveform_output_b_en = ~|compare_output_mode_b;

endmodule : timer16_capture_compare_regs

/* File: testbench/timer16_assertions.sv */
`timescale 1ns/1ps
// Watches the register bus and the interrupt line of the timer.
module timer16_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd_acc;
  logic mapped;
  ////////////////////////////////////////////////////////////////////////////
  // Decode of the bus phase and of the register window.
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  assign mapped = paddr[7:2] >= 6'h22 && paddr[7:2] <= 6'h2e;
  // Bus answers, refusals and read data.
  force_reads_zero_a:
    assert property (rd_acc && paddr[7:2] == 6'h2c |-> prdata == 32'h0)
    else $error("force register read not zero");
  upper_bytes_zero_a:
    assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  unmapped_refused_a:
    assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  mapped_accepted_a:
    assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  setup_no_err_a:
    assert property (psel && !penable |-> !pslverr && pready)
    else $error("error or wait in setup phase");
  read_data_holds_a:
    assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
  reset_quiet_a:
    assert property ($rose(presetn) |-> !irq && prdata == 32'h0)
    else $error("flags or read data not clear after reset");
  access_one_cycle_a:
    assert property (acc |=> !penable)
    else $error("access phase longer than one cycle");
  cover property (acc && pwrite && paddr[7:2] == 6'h2c);
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule : timer16_assertions

bind timer16_capture_compare_regs timer16_assertions CHK (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq);

/* File: testbench/pin_partner.sv */
`timescale 1ns/1ps
// Drives the capture pin and the external count pin after clock edges.
module pin_partner (
  input wire logic pclk,
  output logic capture_input_pin,
  output logic external_count_pin
);
  initial begin
    capture_input_pin = 1'b0;
    external_count_pin = 1'b0;
  end
  // Sets a capture level, then holds it for a number of cycles.
  task automatic cap_set(input logic lvl, input int hold);
    @(posedge pclk);
    capture_input_pin <= lvl;
    repeat (hold) @(posedge pclk);
  endtask : cap_set
  // Each level lasts four cycles, long enough for the synchroniser.
  task automatic ext_toggle(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_count_pin <= ~external_count_pin;
      repeat (3) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : ext_toggle
endmodule : pin_partner

/* File: testbench/timer16_capture_compare_regs_tb.sv */
`timescale 1ns/1ps
module timer16_capture_compare_regs_tb;
  localparam logic [5:0] st = timer16_pkg::IDX_IRQ_STATUS;
  localparam logic [5:0] cc = timer16_pkg::IDX_CAPTURE_CLOCK;
  localparam logic [5:0] cn = timer16_pkg::IDX_COUNTER_L;
  localparam logic [5:0] wc = timer16_pkg::IDX_WAVEFORM_CTRL;
  logic pclk, presetn, psel, penable, pwrite, noted, pready, pslverr, irq;
  logic capture_input_pin, external_count_pin;
  logic waveform_output_a, waveform_output_a_en;
  logic waveform_output_b, waveform_output_b_en;
  logic [7:0] paddr, vector_ack, rdat;
  logic [31:0] pwdata, prdata, lfsr;
  logic [8:0] q[$];
  int num_errors, checked;

  timer16_capture_compare_regs DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .capture_input_pin, .external_count_pin, .vector_ack,
    .waveform_output_a, .waveform_output_a_en, .waveform_output_b,
    .waveform_output_b_en, .irq);
  pin_partner PIN (.pclk, .capture_input_pin, .external_count_pin);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [7:0] d,
                      input logic note);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    noted <= note;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    rdat = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    noted <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    xfer(1'b1, ix, d, 1'b0);
  endtask : wr
  // A checked read notes its expected error bit and byte first.
  task automatic rd_chk(input logic [5:0] ix, input logic [8:0] e);
    q.push_back(e);
    xfer(1'b0, ix, 8'h00, 1'b1);
  endtask : rd_chk
  // The high byte goes first so that the low byte commits the pair.
  task automatic w16(input logic [5:0] ix, input logic [15:0] v);
    wr(ix + 6'h1, v[15:8]);
    wr(ix, v[7:0]);
  endtask : w16
  task automatic lat(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) num_errors++;
  endtask : lat

  // Compares each noted read as its access phase completes.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && noted) begin
      chk($sformatf("read %h", paddr), {7'h0, q.pop_front()},
          {7'h0, pslverr, prdata[7:0]});
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the timer clock is stopped unless a step needs it.
  initial begin
    int n0, n1;
    int dv[6] = '{0, 1, 8, 64, 256, 1024};
    presetn = 1'b0;
    {psel, penable, pwrite, noted} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vector_ack = 8'h00;
    lfsr = 32'ha453;
    num_errors = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 6'h22; i <= 6'h2e; i++) rd_chk(6'(i), 9'h000);
    rd_chk(6'h10, 9'h100);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      w16(6'h22 + 6'(2 * i), lfsr[15:0]);
      rd_chk(6'h22 + 6'(2 * i), {1'b0, lfsr[7:0]});
      rd_chk(6'h23 + 6'(2 * i), {1'b0, lfsr[15:8]});
    end
    wr(wc, 8'hf0);
    wr(timer16_pkg::IDX_FORCE, 8'hc0);
    @(posedge pclk);
    chk("outputs", 16'h3, {14'h0, waveform_output_a, waveform_output_b});
    chk("enable a", 16'h0, {15'h0, waveform_output_a_en});
    chk("enable b", 16'h0, {15'h0, waveform_output_b_en});
    rd_chk(timer16_pkg::IDX_FORCE, 9'h000);
    rd_chk(st, 9'h000);
    wr(wc, 8'ha1);
    wr(timer16_pkg::IDX_FORCE, 8'hc0);
    @(posedge pclk);
    chk("pwm outputs", 16'h3, {14'h0, waveform_output_a, waveform_output_b});
    wr(wc, 8'h00);
    wr(timer16_pkg::IDX_IRQ_MASK, 8'h27);
    w16(cn, 16'h1234);
    PIN.cap_set(1'b1, 8);
    rd_chk(st, 9'h000);
    PIN.cap_set(1'b0, 8);
    rd_chk(st, 9'h020);
    chk("irq", 16'h1, {15'h0, irq});
    rd_chk(timer16_pkg::IDX_CAPTURE_L, 9'h034);
    rd_chk(timer16_pkg::IDX_CAPTURE_H, 9'h012);
    wr(st, 8'h20);
    rd_chk(st, 9'h000);
    wr(cc, 8'h40);
    PIN.cap_set(1'b1, 0);
    lat(n0);
    @(posedge pclk);
    vector_ack <= 8'h20;
    @(posedge pclk);
    vector_ack <= 8'h00;
    @(posedge pclk);
    chk("irq after ack", 16'h0, {15'h0, irq});
    PIN.cap_set(1'b0, 8);
    wr(cc, 8'hc0);
    PIN.cap_set(1'b1, 2);
    PIN.cap_set(1'b0, 8);
    rd_chk(st, 9'h000);
    PIN.cap_set(1'b1, 0);
    lat(n1);
    chk("filter delay", 16'(n0 + 4), 16'(n1));
    wr(st, 8'h20);
    wr(cc, 8'h18);
    PIN.cap_set(1'b0, 8);
    rd_chk(st, 9'h000);
    for (int c = 0; c < 6; c++) begin
      w16(cn, 16'h0000);
      wr(cc, 8'(c));
      repeat (8 * dv[c]) @(posedge pclk);
      wr(cc, 8'h00);
      xfer(1'b0, cn, 8'h00, 1'b0);
      chk("prescaled count", 16'h1, c == 0 ? {15'h0, rdat == 8'h00} :
          {15'h0, rdat >= 8'd7 && rdat <= 8'd11});
    end
    w16(cn, 16'h0000);
    wr(cc, 8'h07);
    PIN.ext_toggle(5);
    wr(cc, 8'h00);
    rd_chk(cn, 9'h003);
    w16(cn, 16'h0000);
    wr(cc, 8'h06);
    PIN.ext_toggle(3);
    wr(cc, 8'h00);
    rd_chk(cn, 9'h002);
    w16(timer16_pkg::IDX_COMPARE_A_L, 16'h0100);
    w16(timer16_pkg::IDX_COMPARE_B_L, 16'h0100);
    wr(st, 8'h27);
    wr(cc, 8'h01);
    w16(cn, 16'h0100);
    wr(cc, 8'h00);
    rd_chk(st, 9'h000);
    wr(cc, 8'h01);
    w16(cn, 16'h00f0);
    repeat (40) @(posedge pclk);
    wr(cc, 8'h00);
    rd_chk(st, 9'h006);
    chk("irq on", 16'h1, {15'h0, irq});
    wr(timer16_pkg::IDX_IRQ_MASK, 8'h00);
    @(posedge pclk);
    chk("irq masked", 16'h0, {15'h0, irq});
    repeat (2) @(posedge pclk);
    results();
  end
endmodule : timer16_capture_compare_regs_tb
